// [design/async_serial_map.vh]
// register map, field positions, reset values and timing counts of the serial block
`ifndef ASYNC_SERIAL_MAP_VH
`define ASYNC_SERIAL_MAP_VH

// ---------------------------------------------------------------
// register byte offsets (word index in address bits 3:2)
// ---------------------------------------------------------------
`define CTRL_OFS           4'h0
`define STATUS_OFS         4'h4
`define DATA_OFS           4'h8
`define BAUD_OFS           4'hc

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTL_TX_EMPTY_IE    0
`define CTL_TX_DONE_IE     1
`define CTL_RX_FULL_IE     2
`define CTL_QUIET_IE       3
`define CTL_TX_ON          4
`define CTL_RX_ON          5
`define CTL_RX_SLEEP       6
`define CTL_BREAK_SEND     7
`define CTL_WAKE_MARK      8
`define CTL_FRAME9         9
`define CTL_PARITY_ON      10
`define CTL_PARITY_ODD     11
`define CTL_QUIET_LONG     12
`define CTL_WIDTH          13
`define CTL_RST            13'h0000

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ST_TX_EMPTY        8
`define ST_TX_DONE         7
`define ST_RX_FULL         6
`define ST_RX_ACTIVE       5
`define ST_LINE_QUIET      4
`define ST_OVERRUN         3
`define ST_NOISE           2
`define ST_FRAMING         1
`define ST_PARITY          0
`define ST_RST             9'h180

// ---------------------------------------------------------------
// timing: oversampling and default divider for 115200 baud at 40 MHz
// ---------------------------------------------------------------
`define OVERSAMPLE         16
`define SAMPLE_A           4'h7
`define SAMPLE_B           4'h8
`define SAMPLE_C           4'h9
`define BAUD_DIV_RST       16'h0016
`define FRAME_BITS_SHORT   4'ha
`define FRAME_BITS_LONG    4'hb

`endif

// [design/serial_tx_shifter.v]
// transmit shifter: frames, break frames and the serial output level
`timescale 1ns/1ps
`default_nettype none
module serial_tx_shifter (
   input  wire       clk_i,        // system clock
   input  wire       reset_n_i,    // async reset, active low
   input  wire       bit_tick_i,   // one-cycle pulse per bit time
   input  wire       tx_on_i,      // transmitter enable
   input  wire       frame9_i,     // nine data bits when set
   input  wire       brk_i,        // send break frames
   input  wire       hold_valid_i, // holding register has a character
   input  wire [8:0] hold_data_i,  // character with parity already applied
   output reg        take_o,       // pulse: holding register moved to shifter
   output reg        busy_o,       // a frame is on the line
   output reg        line_o        // serial output level
);

   reg [9:0] shreg_r; // remaining bits, lsb first
   reg [3:0] cnt_r;   // bits left after the current one

   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   // a new frame is only loaded on a bit boundary, so break and data
   // always wait for the running frame to end
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shreg_r <= 10'h3ff;
         cnt_r   <= 4'h0;
         busy_o  <= 1'b0;
         line_o  <= 1'b1;
         take_o  <= 1'b0;
      end else begin
         take_o <= 1'b0;
         if (!tx_on_i) begin
            busy_o <= 1'b0;
            cnt_r  <= 4'h0;
            line_o <= 1'b1;
         end else if (bit_tick_i) begin
            if (busy_o && cnt_r != 4'h0) begin
               line_o  <= shreg_r[0];
               shreg_r <= {1'b1, shreg_r[9:1]};
               cnt_r   <= cnt_r - 4'h1;
            end else if (brk_i) begin
               busy_o  <= 1'b1;
               line_o  <= 1'b0;
               shreg_r <= 10'h000;
               cnt_r   <= frame9_i ? 4'ha : 4'h9;
            end else if (hold_valid_i) begin
               busy_o  <= 1'b1;
               take_o  <= 1'b1;
               line_o  <= 1'b0;
               shreg_r <= frame9_i ? {1'b1, hold_data_i} : {2'b11, hold_data_i[7:0]};
               cnt_r   <= frame9_i ? 4'ha : 4'h9;
            end else begin
               busy_o <= 1'b0;
               line_o <= 1'b1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// [design/async_serial_ctrl_status.v]
// asynchronous serial transmitter/receiver with Avalon-MM control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_map.vh"
module async_serial_ctrl_status (
   input  wire        clk_i,          // 40 MHz system clock
   input  wire        reset_n_i,      // async reset, active low
   input  wire [3:0]  address_i,      // byte address
   input  wire        read_i,         // read request
   input  wire        write_i,        // write request
   input  wire [3:0]  byteenable_i,   // byte lanes
   input  wire [31:0] writedata_i,    // write data
   output reg  [31:0] readdata_o,     // read data
   output reg         waitrequest_o,  // low on the completing edge
   input  wire        rx_i,           // serial input pin
   output wire        tx_o,           // serial output level
   output reg         tx_oe_o,        // high while the transmitter owns the pin
   output reg         irq_o           // interrupt request, level
);

   // ---------------------------------------------------------------
   // registers and state
   // ---------------------------------------------------------------
   reg  [`CTL_WIDTH-1:0] ctrl_r;
   reg  [15:0] baud_div_r;
   reg  [8:0]  tx_holding_reg_r;
   reg         hold_valid_r;
   reg         wr_late_r;
   reg  [8:0]  rx_holding_reg_r;
   reg         rx_full_flag_r;
   reg         line_quiet_flag_r;
   reg         overrun_flag_r;
   reg         noise_flag_r;
   reg         framing_fault_flag_r;
   reg         parity_fault_flag_r;
   reg         status_seen_r;
   reg         rx_meta_r;
   reg         rx_sync_r;
   reg  [15:0] div_cnt_r;
   reg         tick16_r;
   reg  [3:0]  tx_phase_r;
   reg         bit_tick_r;
   wire        tx_take;
   wire        tx_busy;
   wire        tx_empty_flag = ~hold_valid_r;
   wire        tx_done_flag  = ~tx_busy & ~hold_valid_r;

   wire tx_on          = ctrl_r[`CTL_TX_ON];
   wire rx_on          = ctrl_r[`CTL_RX_ON];
   wire rx_sleep       = ctrl_r[`CTL_RX_SLEEP];
   wire frame9         = ctrl_r[`CTL_FRAME9];
   wire parity_on      = ctrl_r[`CTL_PARITY_ON];
   wire parity_odd_sel = ctrl_r[`CTL_PARITY_ODD];

   // parity bit over the bits below the last data bit
   function par_calc;
      input [8:0] d;
      input       nine;
      input       odd;
      begin
         par_calc = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
      end
   endfunction

   // ---------------------------------------------------------------
   // bus slave: one wait cycle, then completion
   // ---------------------------------------------------------------
   wire       req      = read_i | write_i;
   wire       done     = req & ~waitrequest_o;
   wire       wr_ctrl  = done & write_i & (address_i == `CTRL_OFS);
   wire       wr_data  = done & write_i & (address_i == `DATA_OFS) & byteenable_i[0];
   wire       wr_baud  = done & write_i & (address_i == `BAUD_OFS);
   wire       rd_stat  = done & read_i & (address_i == `STATUS_OFS);
   wire       rd_data  = done & read_i & (address_i == `DATA_OFS);

   wire [8:0] status_word = {tx_empty_flag, tx_done_flag, rx_full_flag_r, rx_active,
                             line_quiet_flag_r, overrun_flag_r, noise_flag_r,
                             framing_fault_flag_r, parity_fault_flag_r};

   reg  [31:0] rdata_nxt;
   // read mux; unmapped or misaligned addresses read zero
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (address_i)
         `CTRL_OFS:   rdata_nxt = {{(32-`CTL_WIDTH){1'b0}}, ctrl_r};
         `STATUS_OFS: rdata_nxt = {23'h000000, status_word};
         `DATA_OFS:   rdata_nxt = {23'h000000, rx_holding_reg_r};
         `BAUD_OFS:   rdata_nxt = {16'h0000, baud_div_r};
         default:     rdata_nxt = 32'h0000_0000;
      endcase
   end

   // waitrequest drops one cycle after a request, data captured with it
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         waitrequest_o <= 1'b1;
         readdata_o    <= 32'h0000_0000;
      end else begin
         waitrequest_o <= ~(req & waitrequest_o);
         if (read_i & waitrequest_o)
            readdata_o <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // control, divider and transmit holding register
   // ---------------------------------------------------------------
   wire wake_now;
   // the hardware wake clears the sleep bit unless software sets it this cycle
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r     <= `CTL_RST;
         baud_div_r <= `BAUD_DIV_RST;
      end else begin
         if (wake_now)
            ctrl_r[`CTL_RX_SLEEP] <= 1'b0;
         if (wr_ctrl) begin
            if (byteenable_i[0])
               ctrl_r[7:0] <= writedata_i[7:0];
            if (byteenable_i[1])
               ctrl_r[`CTL_WIDTH-1:8] <= writedata_i[`CTL_WIDTH-1:8];
         end
         if (wr_baud) begin
            if (byteenable_i[0])
               baud_div_r[7:0] <= writedata_i[7:0];
            if (byteenable_i[1])
               baud_div_r[15:8] <= writedata_i[15:8];
         end
      end
   end

   // a write while the holding register is full replaces the waiting character;
   // a write on the load edge must survive the take pulse that follows it
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_holding_reg_r <= 9'h000;
         hold_valid_r     <= 1'b0;
         wr_late_r        <= 1'b0;
      end else begin
         wr_late_r <= wr_data;
         if (wr_data) begin
            tx_holding_reg_r <= {byteenable_i[1] & writedata_i[8], writedata_i[7:0]};
            hold_valid_r     <= 1'b1;
         end else if (tx_take & ~wr_late_r) begin
            hold_valid_r <= 1'b0;
         end
      end
   end

   // oversampling tick and bit tick; a divider of zero behaves as one
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt_r  <= 16'h0000;
         tick16_r   <= 1'b0;
         tx_phase_r <= 4'h0;
         bit_tick_r <= 1'b0;
      end else begin
         tick16_r   <= 1'b0;
         bit_tick_r <= 1'b0;
         if (div_cnt_r + 16'h0001 >= baud_div_r) begin
            div_cnt_r  <= 16'h0000;
            tick16_r   <= 1'b1;
            tx_phase_r <= tx_phase_r + 4'h1;
            bit_tick_r <= (tx_phase_r == 4'hf);
         end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
         end
      end
   end

   // parity replaces the last data bit of the outgoing character
   wire [8:0] tx_word = !parity_on ? tx_holding_reg_r :
                        frame9 ? {par_calc(tx_holding_reg_r, 1'b1, parity_odd_sel),
                                  tx_holding_reg_r[7:0]} :
                        {tx_holding_reg_r[8],
                         par_calc(tx_holding_reg_r, 1'b0, parity_odd_sel),
                         tx_holding_reg_r[6:0]};

   serial_tx_shifter u_tx (
      .clk_i        (clk_i),
      .reset_n_i    (reset_n_i),
      .bit_tick_i   (bit_tick_r),
      .tx_on_i      (tx_on),
      .frame9_i     (frame9),
      .brk_i        (ctrl_r[`CTL_BREAK_SEND]),
      .hold_valid_i (hold_valid_r),
      .hold_data_i  (tx_word),
      .take_o       (tx_take),
      .busy_o       (tx_busy),
      .line_o       (tx_o)
   );

   // ---------------------------------------------------------------
   // receiver
   // ---------------------------------------------------------------
   localparam [3:0] RX_IDLE  = 4'b0001;
   localparam [3:0] RX_START = 4'b0010;
   localparam [3:0] RX_DATA  = 4'b0100;
   localparam [3:0] RX_STOP  = 4'b1000;

   reg  [3:0] rx_state_r;
   reg  [3:0] rx_phase_r;
   reg  [1:0] smp_r;
   reg  [3:0] rx_bits_r;
   reg  [8:0] rx_shift_r;
   reg  [3:0] ones_cnt_r;
   reg        quiet_armed_r;
   reg        noisy_r;
   wire       rx_active = (rx_state_r != RX_IDLE);
   wire [3:0] frame_len = frame9 ? `FRAME_BITS_LONG : `FRAME_BITS_SHORT;

   // majority of three samples around mid-bit, disagreement is noise
   wire       eval   = tick16_r & (rx_phase_r == `SAMPLE_C);
   wire       bit_v  = (smp_r[1] & smp_r[0]) | (smp_r[1] & rx_sync_r) | (smp_r[0] & rx_sync_r);
   wire       bit_nz = ~((smp_r[1] == smp_r[0]) & (smp_r[0] == rx_sync_r));
   wire       idle_bit  = tick16_r & (rx_state_r == RX_IDLE) & (rx_phase_r == 4'hf);
   wire       frame_end = eval & (rx_state_r == RX_STOP);
   wire [8:0] rx_char   = frame9 ? rx_shift_r : {1'b0, rx_shift_r[8:1]};
   wire       last_bit  = frame9 ? rx_char[8] : rx_char[7];
   wire       mark_wake = frame_end & rx_sleep & ctrl_r[`CTL_WAKE_MARK] & last_bit;
   wire       quiet_hit = quiet_armed_r & (ones_cnt_r >= frame_len);
   wire       idle_wake = quiet_hit & rx_sleep & ~ctrl_r[`CTL_WAKE_MARK];
   assign     wake_now  = mark_wake | idle_wake;
   wire       accept    = frame_end & (~rx_sleep | mark_wake);
   wire       clr_rx    = rd_data & status_seen_r;

   // input pin passes two flip-flops before the receiver sees it
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= rx_i;
         rx_sync_r <= rx_meta_r;
      end
   end

   // frame state machine on the oversampling tick
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_state_r <= RX_IDLE;
         rx_phase_r <= 4'h0;
         smp_r      <= 2'b11;
         rx_bits_r  <= 4'h0;
         rx_shift_r <= 9'h000;
         noisy_r    <= 1'b0;
      end else if (!rx_on) begin
         rx_state_r <= RX_IDLE;
         rx_phase_r <= 4'h0;
      end else if (tick16_r) begin
         rx_phase_r <= rx_phase_r + 4'h1;
         if (rx_phase_r == `SAMPLE_A)
            smp_r[1] <= rx_sync_r;
         if (rx_phase_r == `SAMPLE_B)
            smp_r[0] <= rx_sync_r;
         case (rx_state_r)
            RX_IDLE: begin
               if (!rx_sync_r) begin
                  rx_state_r <= RX_START;
                  rx_phase_r <= 4'h1;
                  noisy_r    <= 1'b0;
               end
            end
            RX_START: begin
               if (eval)
                  rx_state_r <= bit_v ? RX_IDLE : RX_DATA;
               if (eval)
                  rx_bits_r <= 4'h0;
               if (eval)
                  noisy_r <= bit_nz;
            end
            RX_DATA: begin
               if (eval) begin
                  rx_shift_r <= {bit_v, rx_shift_r[8:1]};
                  rx_bits_r  <= rx_bits_r + 4'h1;
                  noisy_r    <= noisy_r | bit_nz;
                  if (rx_bits_r == (frame9 ? 4'h8 : 4'h7))
                     rx_state_r <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (eval)
                  rx_state_r <= RX_IDLE;
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end

   // count one-bits toward an idle line; long mode restarts after each stop bit
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ones_cnt_r    <= 4'h0;
         quiet_armed_r <= 1'b0;
      end else if (!rx_on) begin
         ones_cnt_r    <= 4'h0;
         quiet_armed_r <= 1'b0;
      end else begin
         if (quiet_hit)
            quiet_armed_r <= 1'b0;
         if (eval & (rx_state_r == RX_START) & ~bit_v)
            quiet_armed_r <= 1'b1;
         if (frame_end & ctrl_r[`CTL_QUIET_LONG])
            ones_cnt_r <= 4'h0;
         // idle counts once per bit time; the mid-bit vote counts only inside a frame
         else if (idle_bit | (eval & ((rx_state_r == RX_DATA) | (rx_state_r == RX_STOP))))
            ones_cnt_r <= (idle_bit | bit_v) ?
                          ((ones_cnt_r == 4'hf) ? 4'hf : ones_cnt_r + 4'h1) : 4'h0;
         else if (eval & (rx_state_r == RX_START))
            ones_cnt_r <= 4'h0;
      end
   end

   // ---------------------------------------------------------------
   // receive flags: a set in the clearing cycle wins
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_holding_reg_r     <= 9'h000;
         rx_full_flag_r       <= 1'b0;
         line_quiet_flag_r    <= 1'b0;
         overrun_flag_r       <= 1'b0;
         noise_flag_r         <= 1'b0;
         framing_fault_flag_r <= 1'b0;
         parity_fault_flag_r  <= 1'b0;
         status_seen_r        <= 1'b0;
      end else begin
         if (rd_stat)
            status_seen_r <= |{rx_full_flag_r, line_quiet_flag_r, overrun_flag_r,
                               noise_flag_r, framing_fault_flag_r, parity_fault_flag_r};
         else if (rd_data)
            status_seen_r <= 1'b0;
         if (clr_rx) begin
            rx_full_flag_r       <= 1'b0;
            line_quiet_flag_r    <= 1'b0;
            overrun_flag_r       <= 1'b0;
            noise_flag_r         <= 1'b0;
            framing_fault_flag_r <= 1'b0;
            parity_fault_flag_r  <= 1'b0;
         end
         if (quiet_hit & ~rx_sleep)
            line_quiet_flag_r <= 1'b1;
         if (accept) begin
            if (rx_full_flag_r & ~clr_rx) begin
               overrun_flag_r <= 1'b1;
            end else begin
               rx_holding_reg_r <= rx_char;
               rx_full_flag_r   <= 1'b1;
               if (noisy_r | bit_nz)
                  noise_flag_r <= 1'b1;
               if (!bit_v)
                  framing_fault_flag_r <= 1'b1;
               if (parity_on && par_calc(rx_char, frame9, parity_odd_sel) != last_bit)
                  parity_fault_flag_r <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // pin ownership and interrupt request
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_oe_o <= 1'b0;
         irq_o   <= 1'b0;
      end else begin
         tx_oe_o <= tx_on;
         irq_o   <= (ctrl_r[`CTL_TX_EMPTY_IE] & tx_empty_flag)
                  | (ctrl_r[`CTL_TX_DONE_IE]  & tx_done_flag)
                  | (ctrl_r[`CTL_RX_FULL_IE]  & rx_full_flag_r)
                  | (ctrl_r[`CTL_QUIET_IE]    & line_quiet_flag_r);
      end
   end

endmodule
`default_nettype wire

// [test/serial_ctrl_checker.sv]
// port-level assertions for the serial control and status block
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_checker (
   input wire logic        clk_i,         // system clock
   input wire logic        reset_n_i,     // async reset, active low
   input wire logic [3:0]  address_i,     // byte address
   input wire logic        read_i,        // read request
   input wire logic        write_i,       // write request
   input wire logic [31:0] readdata_o,    // read data
   input wire logic        waitrequest_o, // bus wait
   input wire logic        tx_oe_o        // pin ownership
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // a transfer: seen with wait high, one low cycle, then high again
   sequence s_req; (read_i || write_i) && waitrequest_o; endsequence
   sequence s_done; !waitrequest_o ##1 waitrequest_o; endsequence
   // read data contents are checked only on the completing edge; a_rdata_hold checks its stability on other edges
   wire rd_end = read_i && !waitrequest_o;
   wire ctl_wr = write_i && address_i == 4'h0;
   a_wait_one: assert property (s_req |=> s_done)
      else $error("transfer did not complete in one wait cycle");
   a_wait_idle: assert property (!(read_i || write_i) |=> waitrequest_o)
      else $error("wait dropped without a request");
   a_wait_cause: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
      else $error("wait fell with no request pending");
   a_rdata_hold: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
      else $error("read data moved without a read");
   a_status_top: assert property (rd_end && address_i == 4'h4 |-> readdata_o[31:9] == 23'h0)
      else $error("status upper bits not zero");
   a_data_top: assert property (rd_end && address_i == 4'h8 |-> readdata_o[31:9] == 23'h0)
      else $error("data upper bits not zero");
   a_unmapped_zero: assert property (rd_end && address_i[1:0] != 2'h0 |-> readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_oe_cause: assert property ($changed(tx_oe_o) |-> $past(ctl_wr) || $past(ctl_wr, 2))
      else $error("pin ownership changed without a control write");
endmodule
bind async_serial_ctrl_status serial_ctrl_checker serial_ctrl_checker_inst (
   .clk_i, .reset_n_i, .address_i, .read_i, .write_i, .readdata_o, .waitrequest_o, .tx_oe_o);
`default_nettype wire

// [test/serial_line_model.sv]
// remote transmitter model driving the serial input pin
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
   input wire logic clk_i,  // system clock
   output logic     line_o  // serial line, idles high
);
   initial line_o = 1'b1;
   // one frame, lsb first, 16 clocks a bit at divider 1; stop 0 makes a break
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_o <= f[i];
         repeat (16) @(posedge clk_i);
      end
      if (!stop) begin
         line_o <= 1'b1;
         @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the serial control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [3:0]  address_i = 4'h0;
   logic        read_i = 1'b0;
   logic        write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic [31:0] readdata_o, rdata;
   logic        waitrequest_o, tx_o, tx_oe_o, irq_o, rx_i;
   int          n_mismatch = 0, comparisons = 0, cycles = 0;
   async_serial_ctrl_status async_serial_ctrl_status_inst (.clk_i, .reset_n_i, .address_i,
      .read_i, .write_i, .byteenable_i(4'hf), .writedata_i, .readdata_o, .waitrequest_o,
      .rx_i, .tx_o, .tx_oe_o, .irq_o);
   serial_line_model serial_line_model_inst (.clk_i, .line_o(rx_i));
   // 40 MHz clock
   initial forever #12.5 clk_i = ~clk_i;
   // watchdog: the whole run needs a few thousand cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task conclude;
      if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one avalon transfer; an extra edge keeps back-to-back calls apart
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      read_i <= ~w;
      write_i <= w;
      address_i <= a;
      writedata_i <= d;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0) @(posedge clk_i);
      rdata = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rdata);
   endtask
   // pins are read after the wait, not when the call is made
   task pin(input string nm, input logic e);
      logic s;
      repeat (2) @(posedge clk_i);
      s = (nm == "irq") ? irq_o : (nm == "tx_oe") ? tx_oe_o : tx_o;
      chk(nm, {31'h0, e}, {31'h0, s});
   endtask
   // decode one frame on the output pin at mid-bit
   task tx_frame(input logic [7:0] e);
      @(negedge tx_o);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge clk_i);
         chk("tx_bit", {31'h0, i < 8 ? e[i] : 1'b1}, {31'h0, tx_o});
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd(4'h4, 32'h180, "status");
      rd(4'h1, 32'h0, "unmapped");
      bus(1'b1, 4'h4, 32'h0);
      rd(4'h4, 32'h180, "status");
      bus(1'b1, 4'h0, 32'h1);
      pin("irq", 1'b1);
      bus(1'b1, 4'h0, 32'h0);
      pin("irq", 1'b0);
      bus(1'b1, 4'h0, 32'h2);
      pin("irq", 1'b1);
      bus(1'b1, 4'hc, 32'h1);
      bus(1'b1, 4'h0, 32'h10);
      pin("tx_oe", 1'b1);
      bus(1'b1, 4'h8, 32'hff);
      repeat (40) @(posedge clk_i);
      bus(1'b1, 4'h8, 32'h35);
      rd(4'h4, 32'h0, "status");
      tx_frame(8'h35);
      repeat (16) @(posedge clk_i);
      rd(4'h4, 32'h180, "status");
      bus(1'b1, 4'h0, 32'h24);
      pin("tx_oe", 1'b0);
      serial_line_model_inst.send(8'ha5, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h1c0, "status");
      pin("irq", 1'b1);
      rd(4'h8, 32'ha5, "data");
      rd(4'h4, 32'h180, "status");
      serial_line_model_inst.send(8'h11, 1'b1);
      serial_line_model_inst.send(8'h22, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h1c8, "status");
      rd(4'h8, 32'h11, "data");
      serial_line_model_inst.send(8'h00, 1'b0);
      // the held-low break retriggers a start check that ends once the line is high
      repeat (8) @(posedge clk_i);
      rd(4'h4, 32'h1c2, "status");
      rd(4'h8, 32'h0, "data");
      bus(1'b1, 4'h0, 32'h0);
      serial_line_model_inst.send(8'h33, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h180, "status");
      // odd parity on an eight-bit frame: the last data bit carries parity
      bus(1'b1, 4'h0, 32'hc20);
      serial_line_model_inst.send(8'h81, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h1c1, "status");
      rd(4'h8, 32'h81, "data");
      fork
         serial_line_model_inst.send(8'h01, 1'b1);
         begin
            repeat (80) @(posedge clk_i);
            rd(4'h4, 32'h1a0, "status");
         end
      join
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h1c0, "status");
      rd(4'h8, 32'h1, "data");
      // long idle count starts after the stop bit, so the flag comes late
      bus(1'b1, 4'h0, 32'h1028);
      serial_line_model_inst.send(8'hff, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h1c0, "status");
      pin("irq", 1'b0);
      repeat (160) @(posedge clk_i);
      rd(4'h4, 32'h1d0, "status");
      pin("irq", 1'b1);
      rd(4'h8, 32'hff, "data");
      rd(4'h4, 32'h180, "status");
      // sleeping receiver drops the character, the idle line wakes it
      bus(1'b1, 4'h0, 32'h60);
      serial_line_model_inst.send(8'h44, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(4'h4, 32'h180, "status");
      repeat (150) @(posedge clk_i);
      rd(4'h0, 32'h20, "ctrl");
      // break holds the output low until the running break frame ends
      bus(1'b1, 4'h0, 32'h90);
      repeat (40) @(posedge clk_i);
      pin("tx", 1'b0);
      bus(1'b1, 4'h0, 32'h10);
      repeat (200) @(posedge clk_i);
      pin("tx", 1'b1);
      conclude();
   end
endmodule
`default_nettype wire
